// file: i2c_format_buffer.sv
// Two-wire serial frame engine with own-address matching and data buffers.
// Assumes open-drain SCL/SDA pins resolved outside; registers on a plain port.
module i2c_format_buffer
	import i2c_fmt_pkg::*;
(
	input  wire logic       clk_sys,  // System clock
	input  wire logic       rst_n,    // Synchronous reset
	input  wire logic [1:0] regAddr,  // Register offset
	input  wire logic [7:0] regWdata, // Write data
	input  wire logic       regWr,    // Write strobe
	input  wire logic       regRd,    // Read strobe
	output logic      [7:0] regRdata, // Read data, cycle after strobe
	input  wire logic       sclIn,    // SCL line level
	output logic            sclOut,   // SCL drive level
	output logic            sclOe,    // SCL pulled low while high
	input  wire logic       sdaIn,    // SDA line level
	output logic            sdaOut,   // SDA drive level
	output logic            sdaOe     // SDA pulled low while high
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		engine_state_e state;      // Frame engine
		logic          enable;     // Interface enable
		logic          master;     // Master role
		logic          txSel;      // Transmit select
		logic          irq;        // Interrupt request flag
		logic          formatless; // Formatless switch
		logic          clkExt;     // Clock range extend
		logic          ackRx;      // Last acknowledge seen
		logic          busy;       // Start seen, no stop yet
		logic          selected;   // Addressed as slave
		logic          firstFrame; // Next frame is the address
		logic          rxKick;     // Master receive request
		logic [7:0]    ownP;       // Primary own address
		logic [7:0]    ownS;       // Secondary own address
		logic [7:0]    mode;       // Transfer mode
		logic [7:0]    txBuf;      // Transmit holding buffer
		logic [7:0]    rxBuf;      // Receive holding buffer
		logic [7:0]    shifter;    // Data shifter
		logic [7:0]    rdData;     // Read return
		logic [7:0]    divCnt;     // Half period counter
		logic          txEmpty;    // Transmit buffer empty flag
		logic          rxFull;     // Receive buffer full flag
		logic          shiftFull;  // Shifter holds transmit data
		logic [3:0]    bitIdx;     // Bits sampled this frame
		logic          sclS1;      // SCL synchroniser
		logic          sclS2;
		logic          sclS3;      // Previous SCL for edges
		logic          sdaS1;      // SDA synchroniser
		logic          sdaS2;
		logic          sdaS3;
		logic          sclDrv;     // SCL pulled low
		logic          sdaDrv;     // SDA pulled low
		logic          drvLevel;   // Level driven when enabled
	} state_s;

	state_s st;   // Registered state
	state_s next; // Next state

	logic [7:0] halfDiv;   // Half transfer clock period
	logic       startSeen; // Start condition on the bus

	// Divider only matters while we generate SCL as master
	assign halfDiv = DIV_TABLE[{st.clkExt, st.mode[MODE_CKS_LSB +: 3]}][8:1];
	// Start only recognised outside formatless operation
	assign startSeen = st.enable && !st.formatless && st.sdaS3 && !st.sdaS2
		&& st.sclS2 && st.sclS3;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic       sclRise;
		logic       sclFall;
		logic       stopSeen;
		logic       fsP;
		logic       fsS;
		logic       busFmt;
		logic       ackOn;
		logic [3:0] nData;
		logic       txBit;
		logic       hit;
		logic       complete;
		sclRise  = st.sclS2 && !st.sclS3;
		sclFall  = !st.sclS2 && st.sclS3;
		stopSeen = st.enable && !st.formatless && !st.sdaS3 && st.sdaS2 && st.sclS2 && st.sclS3;
		fsP      = st.ownP[OWN_FMT];
		fsS      = st.ownS[OWN_FMT];
		busFmt   = !st.formatless && !(fsP && fsS);
		ackOn    = !(fsP && fsS);
		nData    = (st.mode[MODE_BC_LSB +: 3] == BC_ZERO) ? FRAME_FULL
			: {1'b0, st.mode[MODE_BC_LSB +: 3]};
		txBit    = st.mode[MODE_ORDER] ? st.shifter[0] : st.shifter[7];
		hit      = (!fsP && st.shifter[7:1] == st.ownP[7:1])
			|| (!fsS && st.shifter[7:1] == st.ownS[7:1]);
		complete = 1'b0;
		next     = st;
		next.rdData = RST_BYTE;
		// Two flops before any logic looks at the pins
		next.sclS1 = sclIn;
		next.sclS2 = st.sclS1;
		next.sclS3 = st.sclS2;
		next.sdaS1 = sdaIn;
		next.sdaS2 = st.sdaS1;
		next.sdaS3 = st.sdaS2;

		// Register writes; shared offsets switch on the enable
		if (regWr)
		begin
			unique case (regAddr)
				ADDR_MODE_OWNP:
					if (st.enable) next.mode = regWdata;
					else next.ownP = regWdata;
				ADDR_DATA_OWNS:
					if (!st.enable) next.ownS = regWdata;
					else if (st.txSel)
					begin
						next.txBuf   = regWdata;
						next.txEmpty = 1'b0;
					end
					else next.rxKick = 1'b1; // Dummy write starts a master receive
				ADDR_CONTROL:
				begin
					next.enable     = regWdata[CTL_ENABLE];
					next.master     = regWdata[CTL_MASTER];
					next.txSel      = regWdata[CTL_TXSEL];
					next.formatless = regWdata[CTL_FMTLESS];
					next.clkExt     = regWdata[CTL_CLKEXT];
					// Writing one never sets the flag
					next.irq        = st.irq && regWdata[CTL_IRQ];
				end
				default: ;
			endcase
		end
		// Register reads; buffer flags never appear here
		if (regRd)
		begin
			unique case (regAddr)
				ADDR_MODE_OWNP: next.rdData = st.enable ? st.mode : st.ownP;
				ADDR_DATA_OWNS:
					if (!st.enable) next.rdData = st.ownS;
					else
					begin
						next.rdData = st.rxBuf;
						if (!st.txSel) next.rxFull = 1'b0;
					end
				ADDR_CONTROL:
				begin
					next.rdData[CTL_ENABLE]  = st.enable;
					next.rdData[CTL_MASTER]  = st.master;
					next.rdData[CTL_TXSEL]   = st.txSel;
					next.rdData[CTL_IRQ]     = st.irq;
					next.rdData[CTL_FMTLESS] = st.formatless;
					next.rdData[CTL_CLKEXT]  = st.clkExt;
					next.rdData[CTL_ACK]     = st.ackRx;
					next.rdData[CTL_BUSY]    = st.busy;
				end
				default: next.rdData = RST_BYTE; // Unmapped reads zero
			endcase
		end

		if (!st.enable)
		begin
			// Disabled: release pins and forget every transfer
			next.state      = S_IDLE;
			next.txEmpty    = 1'b0;
			next.rxFull     = 1'b0;
			next.shiftFull  = 1'b0;
			next.bitIdx     = 4'h0;
			next.divCnt     = RST_BYTE;
			next.busy       = 1'b0;
			next.selected   = 1'b0;
			next.firstFrame = 1'b0;
			next.rxKick     = 1'b0;
			next.sclDrv     = 1'b0;
			next.sdaDrv     = 1'b0;
		end
		else
		begin
			// Master clock: count halves, wait while a slave stretches SCL
			// High half is cut by the pin sync delay so the period stays exact
			if (st.master && (st.state == S_XFER || st.state == S_DONE))
			begin
				if (!st.sclDrv && !st.sclS2) next.divCnt = RST_BYTE;
				else if (st.divCnt == (st.sclDrv ? halfDiv - 8'h01 : halfDiv - 8'h01 - SYNC_LAT))
				begin
					next.divCnt = RST_BYTE;
					// Frame end only pulls low, then holds the bus
					if (st.state == S_XFER || !st.sclDrv) next.sclDrv = !st.sclDrv;
				end
				else next.divCnt = st.divCnt + 8'h01;
			end
			// Load the shifter only between frames
			if (st.state == S_IDLE && st.txSel && !st.txEmpty && !st.shiftFull)
			begin
				next.shifter   = st.txBuf;
				next.shiftFull = 1'b1;
				next.txEmpty   = 1'b1;
			end

			unique case (st.state)
				S_IDLE:
					if (st.master)
					begin
						if (st.txSel ? st.shiftFull : st.rxKick)
						begin
							next.state  = S_XFER;
							next.sclDrv = 1'b1;
							next.divCnt = RST_BYTE;
							next.bitIdx = 4'h0;
							next.rxKick = 1'b0;
							next.sdaDrv = st.txSel && !txBit;
						end
					end
					else if (st.formatless || !busFmt || st.selected || st.firstFrame)
					begin
						// Slave: data ready, or stretch SCL while selected until it is
						if (st.txSel ? st.shiftFull : !st.rxFull)
						begin
							next.state  = S_XFER;
							next.sclDrv = 1'b0;
							next.bitIdx = 4'h0;
							next.sdaDrv = st.txSel && !txBit;
						end
						else next.sclDrv = st.selected;
					end
				S_XFER:
					if (sclRise)
					begin
						if (st.bitIdx < nData)
						begin
							// Short receive frames end at LSB or MSB side by order
							next.shifter = st.mode[MODE_ORDER] ? {st.sdaS2, st.shifter[7:1]}
								: {st.shifter[6:0], st.sdaS2};
							next.bitIdx = st.bitIdx + 4'h1;
							if (st.bitIdx + 4'h1 == nData && !ackOn) complete = 1'b1;
						end
						else
						begin
							next.ackRx = st.sdaS2;
							complete   = 1'b1;
						end
					end
					else if (sclFall)
					begin
						if (st.bitIdx < nData) next.sdaDrv = st.txSel && !txBit;
						else if (st.firstFrame && !st.master && busFmt)
						begin
							// Address frame: acknowledge only our own address
							next.firstFrame = 1'b0;
							if (hit)
							begin
								next.selected = 1'b1;
								next.txSel    = st.shifter[0];
								next.sdaDrv   = 1'b1;
							end
							else
							begin
								next.state  = S_IDLE;
								next.sdaDrv = 1'b0;
							end
						end
						else if (st.master && st.mode[MODE_WAIT] && busFmt)
						begin
							next.irq    = 1'b1;
							next.state  = S_WAIT;
							next.sdaDrv = 1'b0;
						end
						else next.sdaDrv = !st.txSel;
					end
				S_WAIT:
					// SCL stays pulled low until software clears the flag
					if (!st.irq)
					begin
						next.state  = S_XFER;
						next.divCnt = RST_BYTE;
						next.sdaDrv = !st.txSel;
					end
				S_DONE:
					if (sclFall)
					begin
						next.state  = S_IDLE;
						next.sdaDrv = 1'b0;
					end
				default: next.state = S_IDLE;
			endcase

			if (complete)
			begin
				next.irq                    = 1'b1;
				next.mode[MODE_BC_LSB +: 3] = BC_ZERO;
				next.bitIdx                 = 4'h0;
				next.shiftFull              = 1'b0;
				next.state                  = S_DONE;
				if (!st.txSel && !st.rxFull)
				begin
					next.rxBuf  = next.shifter;
					next.rxFull = 1'b1;
				end
			end
			// Bus conditions abort any frame in flight
			if (startSeen)
			begin
				next.busy                   = 1'b1;
				next.firstFrame             = !st.master;
				next.selected               = 1'b0;
				next.bitIdx                 = 4'h0;
				next.mode[MODE_BC_LSB +: 3] = BC_ZERO;
				next.state                  = S_IDLE;
				next.sdaDrv                 = st.master && st.sdaDrv;
			end
			else if (stopSeen)
			begin
				next.busy       = 1'b0;
				next.selected   = 1'b0;
				next.firstFrame = 1'b0;
				next.state      = S_IDLE;
				next.sdaDrv     = 1'b0;
			end
			// Flag sets come last so they win over a clear
			if (!next.txSel) next.txEmpty = 1'b0;
			if (next.txSel && next.formatless && !(st.txSel && st.formatless)) next.txEmpty = 1'b1;
			if (next.txSel && !st.txSel && st.busy) next.txEmpty = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st            <= '0;
			st.state      <= S_IDLE;
			st.ownP       <= RST_OWNP;
			st.ownS       <= RST_OWNS;
			st.mode       <= RST_MODE;
			st.sclS1      <= 1'b1;
			st.sclS2      <= 1'b1;
			st.sclS3      <= 1'b1;
			st.sdaS1      <= 1'b1;
			st.sdaS2      <= 1'b1;
			st.sdaS3      <= 1'b1;
		end
		else st <= next;
	end

	// Outputs straight from flops
	assign regRdata = st.rdData;
	assign sclOut   = st.drvLevel;
	assign sclOe    = st.sclDrv;
	assign sdaOut   = st.drvLevel;
	assign sdaOe    = st.sdaDrv;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_rx_buffer_fill: assert property ($rose(st.rxFull) |-> st.rxBuf == st.shifter && st.state == S_DONE)
		else $error("Receive buffer filled without frame end");
	a_rx_read_clear: assert property (regRd && regAddr == ADDR_DATA_OWNS && st.enable && !st.txSel
		&& st.state != S_XFER |=> !st.rxFull)
		else $error("Receive full flag not cleared by read");
	a_tx_shift_load: assert property (st.enable && st.state == S_IDLE && st.txSel && !st.txEmpty
		&& !st.shiftFull && !regWr |=> st.shiftFull && st.txEmpty && st.shifter == $past(st.txBuf))
		else $error("Shifter not loaded from transmit buffer");
	a_txsel_rise_empty: assert property (st.enable && st.busy && !st.txSel ##1 st.txSel && st.enable
		|-> st.txEmpty)
		else $error("Empty flag not set on switch to transmit");
	a_disable_clears: assert property (!st.enable |=> !st.txEmpty && !st.rxFull && st.state == S_IDLE
		&& !sclOe && !sdaOe)
		else $error("Disabled interface kept state");
	a_mode_readback: assert property (regRd && regAddr == ADDR_MODE_OWNP && st.enable
		|=> regRdata == $past(st.mode))
		else $error("Mode register not read while enabled");
	a_own_readback: assert property (regRd && regAddr == ADDR_DATA_OWNS && !st.enable
		|=> regRdata == $past(st.ownS))
		else $error("Secondary address not read while disabled");
	a_start_count: assert property (startSeen |=> st.busy && st.mode[MODE_BC_LSB +: 3] == BC_ZERO)
		else $error("Start did not clear bit count");
	a_wait_release: assert property (st.state == S_WAIT && !st.irq |=> st.state == S_XFER && sclOe)
		else $error("Wait did not end on flag clear");
	a_wait_hold: assert property (st.state == S_WAIT |-> sclOe)
		else $error("SCL released during wait");
	a_formatless_start: assert property (st.formatless && !st.busy |=> !st.busy)
		else $error("Start detected in formatless operation");
	a_div_bound: assert property (st.master && st.state == S_XFER |-> st.divCnt < halfDiv)
		else $error("Divider count overran half period");
endmodule

// file: i2c_fmt_pkg.sv
// Constants shared by the two-wire format and buffer control block.
// Assumes a single system clock; register port offsets are word indices.
package i2c_fmt_pkg;
	// ------------------------------------------------------------
	// Register port offsets
	// ------------------------------------------------------------
	localparam logic [1:0] ADDR_MODE_OWNP = 2'h0; // Mode when enabled, primary own address otherwise
	localparam logic [1:0] ADDR_DATA_OWNS = 2'h1; // Data when enabled, secondary own address otherwise
	localparam logic [1:0] ADDR_CONTROL   = 2'h2; // Enable, roles, flag and format switches

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] RST_OWNP = 8'h00;
	localparam logic [7:0] RST_OWNS = 8'h01;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODE_ORDER   = 7; // Bit order select
	localparam int MODE_WAIT    = 6; // Master wait before acknowledge
	localparam int MODE_CKS_LSB = 3; // Clock divider select, 3 bits
	localparam int MODE_BC_LSB  = 0; // Frame bit count, 3 bits
	localparam int OWN_FMT      = 0; // Format bit in each own-address register
	localparam int CTL_ENABLE   = 7;
	localparam int CTL_MASTER   = 6;
	localparam int CTL_TXSEL    = 5;
	localparam int CTL_IRQ      = 4;
	localparam int CTL_FMTLESS  = 3;
	localparam int CTL_CLKEXT   = 2;
	localparam int CTL_ACK      = 1;
	localparam int CTL_BUSY     = 0;

	// ------------------------------------------------------------
	// Frame and clock counts
	// ------------------------------------------------------------
	localparam logic [2:0] BC_ZERO    = 3'h0;
	localparam logic [3:0] FRAME_FULL = 4'h8; // Data bits when the count field is zero
	localparam logic [7:0] SYNC_LAT   = 8'h02; // Clocks before a released SCL is seen high
	// Full divisors, index {range extend, select}
	localparam logic [8:0] DIV_TABLE [16] = '{
		9'h01C, 9'h028, 9'h030, 9'h040, 9'h050, 9'h064, 9'h070, 9'h080,
		9'h038, 9'h050, 9'h060, 9'h080, 9'h0A0, 9'h0C8, 9'h0E0, 9'h100};

	// ------------------------------------------------------------
	// Frame engine states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_XFER = 4'b0010,
		S_WAIT = 4'b0100,
		S_DONE = 4'b1000
	} engine_state_e;
endpackage

// file: i2c_bus_partner.sv
// Far side of the two-wire bus: a behavioural external master.
// Assumes pull-ups on both wires; resolves all pull-low enables.
module i2c_bus_partner
(
	input  wire logic clk_sys, // System clock
	input  wire logic sclOe,   // Block pulls SCL low
	input  wire logic sdaOe,   // Block pulls SDA low
	output logic      sclIn,   // Resolved SCL level
	output logic      sdaIn    // Resolved SDA level
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Wire resolution
	// ------------------------------------------------------------
	localparam int HALF = 20; // Clocks per half bit
	logic          sclLow = 1'b0; // We pull SCL low
	logic          sdaLow = 1'b0; // We pull SDA low
	// Wired-AND, released lines float up to the pull-up level
	assign sclIn = ~(sclOe | sclLow);
	assign sdaIn = ~(sdaOe | sdaLow);
	// ------------------------------------------------------------
	// Bus actions
	// ------------------------------------------------------------
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Release SCL and honour stretching, bounded so a stuck slave cannot hang us
	task automatic rise();
		int i;
		i = 0;
		sclLow <= 1'b0;
		@(posedge clk_sys);
		while (sclIn !== 1'b1 && i < 4000)
		begin
			@(posedge clk_sys);
			i++;
		end
		wt(HALF);
	endtask
	// SDA falls while SCL is high
	task automatic start_cond();
		sdaLow <= 1'b1;
		wt(HALF);
		sclLow <= 1'b1;
		wt(HALF);
	endtask
	// Eight data bits MSB first, then one acknowledge clock
	task automatic send_byte(input logic [7:0] d, output logic ack);
		for (int b = 7; b >= 0; b--)
		begin
			sdaLow <= ~d[b];
			wt(HALF);
			rise();
			sclLow <= 1'b1;
		end
		sdaLow <= 1'b0;
		wt(HALF);
		rise();
		ack = ~sdaIn;
		sclLow <= 1'b1;
		wt(HALF);
	endtask
	// SDA rises while SCL is high
	task automatic stop_cond();
		sdaLow <= 1'b1;
		wt(HALF);
		rise();
		sdaLow <= 1'b0;
		wt(HALF);
	endtask
endmodule

// file: i2c_format_and_buffer_control_bench.sv
// Self-checking bench for the two-wire format and buffer block.
// Assumes one 125 MHz clock; the partner model plays the external master.
module i2c_format_and_buffer_control_bench
	import i2c_fmt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals and tables
	// ------------------------------------------------------------
	logic       clk_sys, rst_n, regWr, regRd, ackSeen;
	logic [1:0] regAddr;
	logic [7:0] regWdata, regRdata, rv;
	logic       sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe;
	int         miscompares, comparisons, cycles, n;
	// Divisors by {range extend, select}
	localparam int DIVS [16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};
	// Rows: own primary, own secondary, address byte, acknowledge expected
	localparam logic [24:0] ROWS [8] = '{
		{8'h54, 8'hA2, 8'h54, 1'b1}, {8'h54, 8'hA2, 8'hA2, 1'b1}, {8'h54, 8'hA3, 8'hA2, 1'b0},
		{8'h54, 8'hA3, 8'h54, 1'b1}, {8'h55, 8'hA2, 8'h54, 1'b0}, {8'h55, 8'hA2, 8'hA2, 1'b1},
		{8'h55, 8'hA3, 8'h54, 1'b0}, {8'h54, 8'hA2, 8'h66, 1'b0}};
	i2c_format_buffer i2c_format_buffer_inst (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclIn),
		.sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
	i2c_bus_partner i2c_bus_partner_inst (.clk_sys(clk_sys), .sclOe(sclOe), .sdaOe(sdaOe),
		.sclIn(sclIn), .sdaIn(sdaIn));
	// ------------------------------------------------------------
	// Clock, watchdog and reporting
	// ------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Ceiling well above the longest expected run
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// ------------------------------------------------------------
	// Register port master
	// ------------------------------------------------------------
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic wait_irq();
		int i;
		i = 0;
		rv = 8'h00;
		while (rv[CTL_IRQ] !== 1'b1 && i < 1500)
		begin
			rd(ADDR_CONTROL, rv);
			i++;
		end
	endtask
	// Bounded wait for a level on the SCL enable
	task automatic lvl_wait(input logic l, inout int c);
		while (sclOe !== l && c < 3000)
		begin
			@(posedge clk_sys);
			c++;
		end
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 2'h0;
		regWdata = 8'h00;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Reset values; offset 3 shows no hidden flag
		rd(ADDR_MODE_OWNP, rv);
		check(rv, 8'h00);
		rd(ADDR_DATA_OWNS, rv);
		check(rv, 8'h01);
		rd(ADDR_CONTROL, rv);
		check(rv, 8'h00);
		wr(2'h3, 8'hFF);
		rd(2'h3, rv);
		check(rv, 8'h00);
		// Mode only while enabled, own address only while disabled
		wr(ADDR_MODE_OWNP, 8'hA4);
		wr(ADDR_CONTROL, 8'h80);
		rd(ADDR_MODE_OWNP, rv);
		check(rv, 8'h00);
		wr(ADDR_MODE_OWNP, 8'h28);
		rd(ADDR_MODE_OWNP, rv);
		check(rv, 8'h28);
		wr(ADDR_CONTROL, 8'h00);
		rd(ADDR_MODE_OWNP, rv);
		check(rv, 8'hA4);
		// Address recognition per format bits, then buffered receive
		for (int r = 0; r < 8; r++)
		begin
			wr(ADDR_CONTROL, 8'h00);
			wr(ADDR_MODE_OWNP, ROWS[r][24:17]);
			wr(ADDR_DATA_OWNS, ROWS[r][16:9]);
			wr(ADDR_CONTROL, 8'h80);
			i2c_bus_partner_inst.start_cond();
			i2c_bus_partner_inst.send_byte(ROWS[r][8:1], ackSeen);
			check(ackSeen, ROWS[r][0]);
			if (ROWS[r][0])
			begin
				// Address frame fills the buffer; reading it frees the slave
				rd(ADDR_DATA_OWNS, rv);
				check({8'h00, rv}, {8'h00, ROWS[r][8:1]});
				// Second frame lands only if reading cleared the full flag
				wr(ADDR_CONTROL, 8'h80);
				i2c_bus_partner_inst.send_byte(8'hC3, ackSeen);
				rd(ADDR_DATA_OWNS, rv);
				check(rv, 8'hC3);
				wr(ADDR_CONTROL, 8'h80);
				i2c_bus_partner_inst.send_byte(8'h5A, ackSeen);
				rd(ADDR_DATA_OWNS, rv);
				check(rv, 8'h5A);
			end
			i2c_bus_partner_inst.stop_cond();
		end
		// Master clock period for every divider code
		for (int c = 0; c < 16; c++)
		begin
			wr(ADDR_CONTROL, 8'h00);
			wr(ADDR_CONTROL, {5'b11100, c[3], 2'b00});
			wr(ADDR_MODE_OWNP, {2'b00, c[2:0], 3'b000});
			wr(ADDR_DATA_OWNS, 8'hA5);
			n = 0;
			lvl_wait(1'b0, n);
			lvl_wait(1'b1, n);
			n = 0;
			lvl_wait(1'b0, n);
			lvl_wait(1'b1, n);
			check(16'(n), 16'(DIVS[c]));
			wait_irq();
			check(rv[CTL_IRQ], 1'b1);
			wr(ADDR_CONTROL, 8'h00);
			@(posedge clk_sys);
			#1 check({sclOe, sdaOe}, 2'b00);
		end
		// Wait before acknowledge holds SCL low until the flag is cleared
		wr(ADDR_CONTROL, 8'hE0);
		wr(ADDR_MODE_OWNP, 8'h40);
		wr(ADDR_DATA_OWNS, 8'h3C);
		wait_irq();
		check(rv[CTL_IRQ], 1'b1);
		repeat (60) @(posedge clk_sys);
		#1 check(sclOe, 1'b1);
		wr(ADDR_CONTROL, 8'hE0);
		wait_irq();
		check(rv[CTL_IRQ], 1'b1);
		wr(ADDR_CONTROL, 8'h00);
		end_of_test();
	end
endmodule
